/* rtl/sysclk_sel.sv */
// System clock source selector with postscaler and divide by two
// ==============================================================
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sysclk_sel #(
    parameter int FAST_RC_FREQ_HZ = 7370000
) (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_SYS_RST,
    input  wire logic [2:0]  I_INITIAL_OSC_SELECT,
    input  wire logic [1:0]  I_PRIMARY_OSC_MODE_SEL,
    input  wire logic        I_FAST_RC_CLK,
    input  wire logic        I_PRIMARY_OSC_INPUT_PIN,
    input  wire logic        I_CRYSTAL_CLK,
    input  wire logic        I_PLL_CLK,
    input  wire logic        I_SECONDARY_OSC_CLK,
    input  wire logic        I_LOW_POWER_RC_CLK,
    input  wire logic [3:0]  I_ADDR,
    input  wire logic [15:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [15:0] O_RDATA,
    output logic             O_PLL_REF_CLK,
    output logic             O_SYSTEM_OSC_OUTPUT,
    output logic             O_INSTRUCTION_CLOCK,
    output logic             O_PERIPHERAL_TIME_BASE,
    output logic             O_WATCHDOG_REF_CLK,
    output logic             O_FAIL_SAFE_MONITOR_REF_CLK,
    output logic [31:0]      O_FAST_RC_FREQ_HZ,
    output sysclk_pkg::sysclk_mode_e O_MODE
);
    import sysclk_pkg::*;

    // ==========================================================
    // Helpers
    function automatic sysclk_mode_e decode_mode(input logic [2:0] sel,
                                                 input logic [1:0] pri);
        sysclk_mode_e m;
        m = MODE_DIVN;
        case (sel)
            SEL_FAST_RC:       m = MODE_FAST_RC;
            SEL_FAST_RC_PLL:   m = MODE_FAST_PLL;
            SEL_PRIMARY:       m = (pri == PRI_HIGH_SPEED) ? MODE_HI_SPEED :
                                   (pri == PRI_CRYSTAL) ? MODE_CRYSTAL :
                                   MODE_EXT_CLK;
            SEL_PRIMARY_PLL:   m = (pri == PRI_HIGH_SPEED) ? MODE_HI_SPEED_PLL :
                                   (pri == PRI_CRYSTAL) ? MODE_CRYSTAL_PLL :
                                   MODE_EXT_CLK_PLL;
            SEL_SECONDARY:     m = MODE_SECONDARY;
            SEL_LOW_POWER_RC:  m = MODE_LOW_RC;
            SEL_FAST_RC_DIV16: m = MODE_DIV16;
            default:           m = MODE_DIVN;
        endcase
        return m;
    endfunction

    function automatic logic is_pll(input sysclk_mode_e m);
        return (m == MODE_FAST_PLL) || (m == MODE_HI_SPEED_PLL) ||
               (m == MODE_CRYSTAL_PLL) || (m == MODE_EXT_CLK_PLL);
    endfunction

    // ==========================================================
    // Configuration capture
    logic         cfg_taken_ff;
    sysclk_mode_e mode_ff;
    sysclk_mode_e nxt_mode;
    logic [2:0]   switch_sel_ff;
    logic         switch_req_ff;

    always_comb begin
        nxt_mode = mode_ff;
        if (!cfg_taken_ff) begin
            nxt_mode = decode_mode(I_INITIAL_OSC_SELECT,
                                   I_PRIMARY_OSC_MODE_SEL);
        end else if (switch_req_ff) begin
            nxt_mode = decode_mode(switch_sel_ff, I_PRIMARY_OSC_MODE_SEL);
        end
    end

    // Sampled once after reset release, so later glitches on I_INITIAL_OSC_SELECT are ignored; a switch re-reads I_PRIMARY_OSC_MODE_SEL
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            cfg_taken_ff <= 1'b0;
            mode_ff      <= MODE_DIVN;
        end else begin
            cfg_taken_ff <= 1'b1;
            mode_ff      <= nxt_mode;
        end
    end

    // ==========================================================
    // Registers
    logic [15:0] clock_divider_reg_ff;
    logic [15:0] tune_ff;

    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            clock_divider_reg_ff <= CLOCK_DIVIDER_REG_RESET;
            tune_ff   <= TUNE_RESET;
        end else if (I_WR) begin
            if (I_ADDR == ADDR_CLOCK_DIVIDER) clock_divider_reg_ff <= I_WDATA;
            if (I_ADDR == ADDR_OSC_TUNE)      tune_ff <= I_WDATA;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            switch_req_ff <= 1'b0;
            switch_sel_ff <= SEL_ERASED;
        end else begin
            switch_req_ff <= I_WR && (I_ADDR == ADDR_SWITCH);
            if (I_WR && (I_ADDR == ADDR_SWITCH)) switch_sel_ff <= I_WDATA[2:0];
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_RDATA <= 16'h0000;
        end else if (I_RD) begin
            case (I_ADDR)
                ADDR_CLOCK_DIVIDER: O_RDATA <= clock_divider_reg_ff;
                ADDR_OSC_TUNE:      O_RDATA <= tune_ff;
                ADDR_STATUS:        O_RDATA <= {11'h000,
                                                is_pll(mode_ff), mode_ff};
                ADDR_SWITCH:        O_RDATA <= {13'h0000, switch_sel_ff};
                default:            O_RDATA <= 16'h0000;
            endcase
        end else begin
            O_RDATA <= 16'h0000;
        end
    end

    // Trim modelled as signed step of 1/1000 of nominal per code
    logic signed [6:0] tune_s;
    assign tune_s = {tune_ff[TUNE_W-1], tune_ff[TUNE_W-1:0]};
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_FAST_RC_FREQ_HZ <= 32'(FAST_RC_FREQ_HZ);
        end else begin
            O_FAST_RC_FREQ_HZ <= 32'(FAST_RC_FREQ_HZ +
                                     int'(tune_s) * TUNE_STEP_HZ);
        end
    end

    // ==========================================================
    // Fast RC postscaler, synchronous binary counter clocked by the oscillator itself
    logic [7:0] rc_post_cnt_ff;
    logic [2:0] post_sel;
    logic       rc_div_n;
    logic       rc_div16;
    assign post_sel = clock_divider_reg_ff[POSTSCALE_MSB:POSTSCALE_LSB];

    always_ff @(posedge I_FAST_RC_CLK) begin
        if (I_SYS_RST) rc_post_cnt_ff <= 8'h00;
        else           rc_post_cnt_ff <= rc_post_cnt_ff + 8'h01;
    end
    // Field 0 gives 1:2, field 7 gives 1:256
    assign rc_div_n = rc_post_cnt_ff[post_sel];
    assign rc_div16 = rc_post_cnt_ff[DIV16_LOG2-1];

    // ==========================================================
    // Source mux; a glitchless switch is left to the clock cells
    logic pri_clk;
    assign pri_clk = (mode_ff == MODE_EXT_CLK ||
                      mode_ff == MODE_EXT_CLK_PLL) ?
                     I_PRIMARY_OSC_INPUT_PIN : I_CRYSTAL_CLK;

    always_comb begin
        O_PLL_REF_CLK = (mode_ff == MODE_FAST_PLL) ? I_FAST_RC_CLK
                                                    : pri_clk;
        case (mode_ff)
            MODE_FAST_RC:   O_SYSTEM_OSC_OUTPUT = I_FAST_RC_CLK;
            MODE_FAST_PLL,
            MODE_HI_SPEED_PLL,
            MODE_CRYSTAL_PLL,
            MODE_EXT_CLK_PLL: O_SYSTEM_OSC_OUTPUT = I_PLL_CLK;
            MODE_HI_SPEED,
            MODE_CRYSTAL,
            MODE_EXT_CLK:   O_SYSTEM_OSC_OUTPUT = pri_clk;
            MODE_SECONDARY: O_SYSTEM_OSC_OUTPUT = I_SECONDARY_OSC_CLK;
            MODE_LOW_RC:    O_SYSTEM_OSC_OUTPUT = I_LOW_POWER_RC_CLK;
            MODE_DIV16:     O_SYSTEM_OSC_OUTPUT = rc_div16;
            default:        O_SYSTEM_OSC_OUTPUT = rc_div_n;
        endcase
        // Keeps edges on the halver during reset; slow or gated
        // sources would otherwise leave it unknown for good
        if (I_SYS_RST) begin
            O_SYSTEM_OSC_OUTPUT = I_FAST_RC_CLK;
        end
    end

    assign O_WATCHDOG_REF_CLK          = I_LOW_POWER_RC_CLK;
    assign O_FAIL_SAFE_MONITOR_REF_CLK = I_LOW_POWER_RC_CLK;
    assign O_MODE                      = mode_ff;

    // ==========================================================
    // Divide by two; one stage for both so they never drift apart
    // Up to MAX_SYSOSC_HZ in, giving MAX_MIPS out
    logic half_ff;
    always_ff @(posedge O_SYSTEM_OSC_OUTPUT) begin
        if (I_SYS_RST) half_ff <= 1'b0;
        else           half_ff <= ~half_ff;
    end
    assign O_INSTRUCTION_CLOCK    = half_ff;
    assign O_PERIPHERAL_TIME_BASE = half_ff;

    // ==========================================================
    // Checks
    sequence reset_release_s;
        $fell(I_SYS_RST);
    endsequence

    mode_capture_a: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        !cfg_taken_ff |=> mode_ff == $past(decode_mode(I_INITIAL_OSC_SELECT,
                                       I_PRIMARY_OSC_MODE_SEL)))
        else $error("Mode not taken from configuration");

    mode_hold_a: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        (cfg_taken_ff && !switch_req_ff) |=> $stable(mode_ff))
        else $error("Mode changed without switch");

    erased_default_a: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        (!cfg_taken_ff && I_INITIAL_OSC_SELECT == SEL_ERASED)
        |=> mode_ff == MODE_DIVN)
        else $error("Erased selection not fast RC");

    taken_after_a: assert property (@(posedge I_REF_CLK)
        reset_release_s |-> ##1 cfg_taken_ff)
        else $error("Configuration not sampled after reset");

    pll_route_a: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        is_pll(mode_ff) |-> O_SYSTEM_OSC_OUTPUT == I_PLL_CLK)
        else $error("PLL not in path");

    ec_pin_a: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        mode_ff == MODE_EXT_CLK |->
        O_SYSTEM_OSC_OUTPUT == I_PRIMARY_OSC_INPUT_PIN)
        else $error("External clock pin not used");

    pll_ref_a: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        mode_ff == MODE_FAST_PLL |-> O_PLL_REF_CLK == I_FAST_RC_CLK)
        else $error("PLL reference not fast RC");

    low_rc_src_a: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        mode_ff == MODE_LOW_RC |-> O_SYSTEM_OSC_OUTPUT == I_LOW_POWER_RC_CLK)
        else $error("Low-power RC not selected");

    div16_src_a: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        mode_ff == MODE_DIV16 |-> O_SYSTEM_OSC_OUTPUT == rc_div16)
        else $error("Divide by 16 tap not selected");

    switch_apply_a: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        (cfg_taken_ff && switch_req_ff) |=>
        mode_ff == $past(decode_mode(switch_sel_ff, I_PRIMARY_OSC_MODE_SEL)))
        else $error("Clock switch not applied");

    tune_read_a: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        (I_RD && I_ADDR == ADDR_OSC_TUNE) |=> O_RDATA == $past(tune_ff))
        else $error("Tune readback wrong");

    tune_follow_a: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        (I_WR && I_ADDR == ADDR_OSC_TUNE) |=> ##1
        O_FAST_RC_FREQ_HZ == 32'(FAST_RC_FREQ_HZ + int'(tune_s) * TUNE_STEP_HZ))
        else $error("Frequency not following tune");

    postscale_a: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST)
        (I_WR && I_ADDR == ADDR_CLOCK_DIVIDER) |=>
        post_sel == $past(I_WDATA[POSTSCALE_MSB:POSTSCALE_LSB]))
        else $error("Postscaler field not updated");

    same_phase_a: assert property (@(posedge I_REF_CLK)
        O_INSTRUCTION_CLOCK == O_PERIPHERAL_TIME_BASE)
        else $error("Time base and instruction clock differ");

    slow_ref_a: assert property (@(posedge I_REF_CLK)
        O_WATCHDOG_REF_CLK == I_LOW_POWER_RC_CLK &&
        O_FAIL_SAFE_MONITOR_REF_CLK == I_LOW_POWER_RC_CLK)
        else $error("Low-power RC reference missing");
endmodule
`default_nettype wire

/* rtl/sysclk_pkg.sv */
// Constants for the system clock source selector
package sysclk_pkg;
    // ==========================================================
    // Source selection encodings
    localparam logic [2:0] SEL_FAST_RC      = 3'h0;
    localparam logic [2:0] SEL_FAST_RC_PLL  = 3'h1;
    localparam logic [2:0] SEL_PRIMARY      = 3'h2;
    localparam logic [2:0] SEL_PRIMARY_PLL  = 3'h3;
    localparam logic [2:0] SEL_SECONDARY    = 3'h4;
    localparam logic [2:0] SEL_LOW_POWER_RC = 3'h5;
    localparam logic [2:0] SEL_FAST_RC_DIV16 = 3'h6;
    localparam logic [2:0] SEL_FAST_RC_DIVN = 3'h7;
    localparam logic [2:0] SEL_ERASED       = 3'h7;
    // ==========================================================
    // Primary oscillator modes
    localparam logic [1:0] PRI_EXTERNAL_CLOCK = 2'h0;
    localparam logic [1:0] PRI_CRYSTAL        = 2'h1;
    localparam logic [1:0] PRI_HIGH_SPEED     = 2'h2;
    localparam logic [1:0] PRI_ERASED         = 2'h3;
    // ==========================================================
    // Register map and fields
    localparam logic [3:0] ADDR_CLOCK_DIVIDER = 4'h0;
    localparam logic [3:0] ADDR_OSC_TUNE      = 4'h1;
    localparam logic [3:0] ADDR_STATUS        = 4'h2;
    localparam logic [3:0] ADDR_SWITCH        = 4'h3;
    localparam int         POSTSCALE_LSB      = 8;
    localparam int         POSTSCALE_MSB      = 10;
    localparam logic [15:0] CLOCK_DIVIDER_REG_RESET      = 16'h0000;
    localparam logic [15:0] TUNE_RESET        = 16'h0000;
    localparam int         TUNE_W             = 6;
    // ==========================================================
    // Nominal frequencies and limits
    localparam int FAST_RC_HZ   = 7370000;
    localparam int LOW_POWER_HZ = 32768;
    localparam int MAX_MIPS     = 50;
    localparam int MAX_SYSOSC_HZ = MAX_MIPS * 2 * 1000000;
    localparam int DIV16_LOG2   = 4;
    localparam int TUNE_STEP_HZ = FAST_RC_HZ / 1000;
    // ==========================================================
    // Clock mode enumeration, one value for each of twelve modes
    typedef enum logic [3:0] {
        MODE_FAST_RC   = 4'h0,
        MODE_FAST_PLL  = 4'h1,
        MODE_EXT_CLK       = 4'h3,
        MODE_CRYSTAL       = 4'h2,
        MODE_HI_SPEED      = 4'h6,
        MODE_EXT_CLK_PLL   = 4'h7,
        MODE_CRYSTAL_PLL   = 4'h5,
        MODE_HI_SPEED_PLL  = 4'h4,
        MODE_SECONDARY = 4'hc,
        MODE_LOW_RC    = 4'hd,
        MODE_DIV16     = 4'hf,
        MODE_DIVN      = 4'he
    } sysclk_mode_e;
endpackage

/* sim/sysclk_osc_model.sv */
// Behavioural oscillator sources facing the clock selector
`timescale 1ns/1ps
`default_nettype none
module sysclk_osc_model #(
    parameter int FAST_HZ = 7370000,
    parameter int SLOW_HZ = 32768,
    parameter int CRYS_HZ = 8000000,
    parameter int PIN_HZ  = 20000000,
    parameter int PLL_HZ  = 100000000
) (
    output logic o_fast_clk,
    output logic o_crys_clk,
    output logic o_pin_clk,
    output logic o_pll_clk,
    output logic o_sec_clk,
    output logic o_slow_clk
);
    // ==========================================================
    // Free running sources
    // PLL taken as locked; lock time is not modelled
    initial begin
        {o_fast_clk, o_crys_clk, o_pin_clk, o_pll_clk} = 4'h0;
        o_slow_clk = 1'b0;
        // Antiphase so the two slow sources can be told apart
        o_sec_clk = 1'b1;
    end
    always #(5.0e8 / FAST_HZ) o_fast_clk = ~o_fast_clk;
    always #(5.0e8 / CRYS_HZ) o_crys_clk = ~o_crys_clk;
    always #(5.0e8 / PIN_HZ) o_pin_clk = ~o_pin_clk;
    always #(5.0e8 / PLL_HZ) o_pll_clk = ~o_pll_clk;
    always #(5.0e8 / SLOW_HZ) o_sec_clk = ~o_sec_clk;
    always #(5.0e8 / SLOW_HZ) o_slow_clk = ~o_slow_clk;
endmodule
`default_nettype wire

/* sim/tb_system_clock_source_select.sv */
// Self-checking bench for the system clock source selector
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_source_select;
    import sysclk_pkg::*;
    logic         clk, rst, wr, rd;
    logic [2:0]   sel;
    logic [1:0]   pri;
    logic [3:0]   addr;
    logic [15:0]  wdata, rdata, d;
    logic         fast_c, crys_c, pin_c, pll_c, sec_c, slow_c;
    logic         pll_ref, sys_o, instr, perif, wdog, mon;
    logic [31:0]  freq;
    sysclk_mode_e mode;
    int           miscompares, tests_run, cycles, fast_cnt, sys_cnt, base;

    sysclk_osc_model i_sysclk_osc_model (.o_fast_clk(fast_c),
        .o_crys_clk(crys_c), .o_pin_clk(pin_c), .o_pll_clk(pll_c),
        .o_sec_clk(sec_c), .o_slow_clk(slow_c));
    sysclk_sel #(.FAST_RC_FREQ_HZ(FAST_RC_HZ)) i_sysclk_sel (
        .I_REF_CLK(clk), .I_SYS_RST(rst), .I_INITIAL_OSC_SELECT(sel),
        .I_PRIMARY_OSC_MODE_SEL(pri), .I_FAST_RC_CLK(fast_c),
        .I_PRIMARY_OSC_INPUT_PIN(pin_c), .I_CRYSTAL_CLK(crys_c),
        .I_PLL_CLK(pll_c), .I_SECONDARY_OSC_CLK(sec_c),
        .I_LOW_POWER_RC_CLK(slow_c), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_PLL_REF_CLK(pll_ref),
        .O_SYSTEM_OSC_OUTPUT(sys_o), .O_INSTRUCTION_CLOCK(instr),
        .O_PERIPHERAL_TIME_BASE(perif), .O_WATCHDOG_REF_CLK(wdog),
        .O_FAIL_SAFE_MONITOR_REF_CLK(mon), .O_FAST_RC_FREQ_HZ(freq),
        .O_MODE(mode));

    // ==========================================================
    // Clock, edge counters and hang guard
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge fast_c) fast_cnt++;
    always @(posedge sys_o) sys_cnt++;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            conclude();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic do_reset(input logic [2:0] s, input logic [1:0] p);
        @(posedge clk);
        rst <= 1'b1;
        sel <= s;
        pri <= p;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // First period discarded: divider may be mid-count
    task automatic post_ratio(input int f);
        repeat (2) @(posedge sys_o);
        base = fast_cnt;
        @(posedge sys_o);
        check("postscale", fast_cnt - base, f);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    function automatic sysclk_mode_e exp_mode(input logic [2:0] s,
                                               input logic [1:0] p);
        case (s)
            3'h0: return MODE_FAST_RC;
            3'h1: return MODE_FAST_PLL;
            3'h2: return p == 2'h0 ? MODE_EXT_CLK :
                         p == 2'h1 ? MODE_CRYSTAL : MODE_HI_SPEED;
            3'h3: return p == 2'h0 ? MODE_EXT_CLK_PLL :
                         p == 2'h1 ? MODE_CRYSTAL_PLL : MODE_HI_SPEED_PLL;
            3'h4: return MODE_SECONDARY;
            3'h5: return MODE_LOW_RC;
            3'h6: return MODE_DIV16;
            default: return MODE_DIVN;
        endcase
    endfunction
    function automatic logic exp_src(input logic [2:0] s,
                                     input logic [1:0] p);
        case (s)
            3'h0: return fast_c;
            3'h1, 3'h3: return pll_c;
            3'h2: return p == 2'h0 ? pin_c : crys_c;
            3'h4: return sec_c;
            default: return slow_c;
        endcase
    endfunction

    // ==========================================================
    // Test sequence
    initial begin
        {wr, rd, addr, wdata} = '0;
        rst = 1'b1;
        {miscompares, tests_run, cycles, fast_cnt, sys_cnt} = '0;
        sel = 3'h7;
        pri = 2'h3;
        do_reset(3'h7, 2'h3);
        check("erased mode", mode, MODE_DIVN);
        check("nominal freq", freq, FAST_RC_HZ);
        rd_reg(ADDR_CLOCK_DIVIDER);
        check("divider reset", d, CLOCK_DIVIDER_REG_RESET);
        rd_reg(4'h9);
        check("unmapped read", d, 16'h0000);
        wr_reg(ADDR_OSC_TUNE, 16'h0005);
        @(posedge clk);
        #1 check("tune up", freq, FAST_RC_HZ + 5 * TUNE_STEP_HZ);
        wr_reg(ADDR_OSC_TUNE, 16'h003f);
        @(posedge clk);
        #1 check("tune down", freq, FAST_RC_HZ - TUNE_STEP_HZ);
        for (int k = 0; k < 8; k++) begin
            wr_reg(ADDR_CLOCK_DIVIDER, {5'h0, k[2:0], 8'h00});
            rd_reg(ADDR_CLOCK_DIVIDER);
            check("divider", d, {5'h0, k[2:0], 8'h00});
            post_ratio(2 << k);
        end
        do_reset(3'h6, 2'h3);
        post_ratio(16);
        for (int s = 0; s < 8; s++) begin
            for (int p = 0; p < 3; p++) begin
                do_reset(s[2:0], p[1:0]);
                check("mode", mode, exp_mode(s[2:0], p[1:0]));
                rd_reg(ADDR_STATUS);
                check("status", d, {11'h0, (s == 1 || s == 3),
                      exp_mode(s[2:0], p[1:0])});
                // Odd offset keeps samples off source edges
                for (int n = 0; n < 8 && s < 6; n++) begin
                    repeat (23) @(negedge clk);
                    #1.3 check("sysosc", sys_o, exp_src(s[2:0], p[1:0]));
                    check("pll ref", pll_ref, s == 1 ? fast_c :
                          ((s == 2 || s == 3) && p == 0) ? pin_c :
                          crys_c);
                    check("wdog ref", wdog, slow_c);
                    check("monitor ref", mon, slow_c);
                    check("periph", perif, instr);
                end
            end
        end
        do_reset(3'h3, 2'h2);
        repeat (2) @(posedge instr);
        base = sys_cnt;
        @(posedge instr);
        check("instr ratio", sys_cnt - base, 2);
        @(posedge clk);
        sel <= 3'h5;
        pri <= 2'h0;
        repeat (4) @(posedge clk);
        #1 check("held mode", mode, MODE_HI_SPEED_PLL);
        wr_reg(ADDR_SWITCH, 16'h0001);
        @(posedge clk);
        #1 check("switched", mode, MODE_FAST_PLL);
        rd_reg(ADDR_SWITCH);
        check("switch reg", d, 16'h0001);
        conclude();
    end
endmodule
`default_nettype wire
